// ==== design/modem_serial_params.svh ====
// Constants shared by both ends of the modem serial link
`ifndef MODEM_SERIAL_PARAMS_SVH
`define MODEM_SERIAL_PARAMS_SVH

// Clocking
`define CLK_HZ 25000000
`define SCK_MAX_HZ 8000000
`define SCK_HALF_CYC ((`CLK_HZ + 2 * `SCK_MAX_HZ - 1) / (2 * `SCK_MAX_HZ))
`define HALF_CNT_LAST 3'((`SCK_HALF_CYC) - 1)
`define REF_OSC_HZ 16000000

// Burst and header layout
`define BIT_CNT_LAST 3'h7
`define HDR_RW_BIT 7
`define HDR_ADDR_HI 5
`define HDR_ADDR_LO 0
`define HDR_UNUSED 1'h0
`define MIN_FRAME_BYTES 2'h3
`define BYTE_ZERO 8'h00

// Device register map
`define ADDR_CLKOUT_CTL 6'h0A
`define ADDR_STEP 6'h01
`define REG_COUNT 64
`define REG_RESET 16'h0000
`define TRIM_HI 15
`define TRIM_LO 8
`define CLKSEL_HI 2
`define CLKSEL_LO 0
`define CLKSEL_DIRECT 3'h0
`define REF_DIV_W 7

// Host command registers
`define HREG_CTRL 4'h0
`define HREG_TX 4'h1
`define HREG_RX 4'h2
`define HREG_STATUS 4'h3
`define CTRL_READ_BIT 7
`define CTRL_GO_BIT 8
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define HOST_BYTE_HDR 2'h0
`define HOST_BYTE_HI 2'h1
`define HOST_BYTE_LO 2'h2
`define RDATA_IDLE 16'h0000

`endif

// ==== design/modem_serial_pkg.sv ====
// Types shared by both ends of the modem serial link
`default_nettype none
`include "modem_serial_params.svh"
package modem_serial_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [15:0] word_t;
	typedef logic [5:0] addr_t;
	typedef logic [3:0] host_addr_t;
	typedef enum logic [1:0] {DEV_IDLE, DEV_HEADER, DEV_DATA, DEV_IGNORE} dev_state_t;
	typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_TAIL} host_state_t;
endpackage
`default_nettype wire

// ==== design/serial_link_if.sv ====
// Four-wire serial link between host master and modem slave
`timescale 1ns/1ps
`default_nettype none
interface serial_link_if;
	logic sck;
	logic csN;
	logic mosi;
	logic miso;
	logic misoOe;
	logic misoLine;

	// Undriven data line reads low
	assign misoLine = misoOe & miso;

	modport device (
		input sck,
		input csN,
		input mosi,
		output miso,
		output misoOe
	);

	modport host (
		output sck,
		output csN,
		output mosi,
		input misoLine
	);
endinterface
`default_nettype wire

// ==== design/byte_shifter.sv ====
// Eight-bit MSB-first shifter for mode zero bursts
`timescale 1ns/1ps
`default_nettype none
module byte_shifter (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic loadEn,
	input wire modem_serial_pkg::byte_t loadByte,
	input wire logic sampleEn,
	input wire logic shiftEn,
	input wire logic serIn,
	output logic serOut,
	output modem_serial_pkg::byte_t rxByte,
	output logic byteDone
);
	import modem_serial_pkg::*;

	byte_t outShift_reg;
	logic [6:0] inShift_reg;
	logic [2:0] bitCnt_reg;
	byte_t hold_reg;
	logic pend_reg;

	assign serOut = outShift_reg[7];
	assign rxByte = {inShift_reg, serIn};
	assign byteDone = sampleEn & (bitCnt_reg == `BIT_CNT_LAST);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bitCnt_reg <= 3'h0;
		end else if (clear) begin
			bitCnt_reg <= 3'h0;
		end else if (sampleEn) begin
			bitCnt_reg <= bitCnt_reg + 3'h1;
		end
	end

	// Capture on the rising edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			inShift_reg <= 7'h00;
		end else if (sampleEn) begin
			inShift_reg <= rxByte[6:0];
		end
	end

	// Byte loaded at a burst end waits for the next falling edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_reg <= `BYTE_ZERO;
			pend_reg <= 1'b0;
		end else if (loadEn && byteDone) begin
			hold_reg <= loadByte;
			pend_reg <= 1'b1;
		end else if (clear || shiftEn) begin
			pend_reg <= 1'b0;
		end
	end

	// Change on falling edge; last bit stands until then
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			outShift_reg <= `BYTE_ZERO;
		end else if (loadEn && !byteDone) begin
			outShift_reg <= loadByte;
		end else if (clear) begin
			outShift_reg <= `BYTE_ZERO;
		end else if (shiftEn && pend_reg) begin
			outShift_reg <= hold_reg;
		end else if (shiftEn && bitCnt_reg != 3'h0) begin
			outShift_reg <= {outShift_reg[6:0], 1'b0};
		end
	end
endmodule
`default_nettype wire

// ==== design/modem_serial_slave.sv ====
// Modem end of the serial link: slave port and register file
// What this block does
// - Modem is slave only, never drives clock
// - Transaction fits one select low, three bursts
// - Sample on rising edge, change on falling
// - Host uses clock phase and polarity zero
// - Host sends on MOSI, modem on MISO
// - Shifter static; transfers use core clock
// - Bursts are eight bits, MSB first
// - Host serial clock at most 8 MHz
// - Select falling starts transaction, header next
// - First burst is header: address and direction
// - Writes on MOSI, reads on MISO
// - Only one data line valid per burst
// - Payload at least two bytes
// - Select rising ends the transaction
// - Trim field bits 15-8 of register 0A
// - Trim zero is highest, larger is lower
// - Select 000 outputs undivided reference clock
// - Reference divided by two to the select for select 1-7, 16 MHz reference
// - Port works only when idle and enabled
`timescale 1ns/1ps
`default_nettype none
module modem_serial_slave (
	input wire logic clk,
	input wire logic rst_n,
	serial_link_if.device link,
	input wire logic modemIdle,
	input wire logic serialPortOn,
	input wire logic oscillatorInputPin,
	output logic [7:0] oscWarpTrim,
	output logic referenceClockOutPin,
	output logic frameShort
);
	import modem_serial_pkg::*;

	dev_state_t state_reg;
	logic sckPrev_reg;
	logic csPrev_reg;
	logic refPrev_reg;
	addr_t addr_reg;
	logic readAcc_reg;
	logic lowPhase_reg;
	byte_t hiByte_reg;
	logic [1:0] byteCount_reg;
	logic misoOe_reg;
	logic frameShort_reg;
	logic refOut_reg;
	logic [`REF_DIV_W-1:0] refDiv_reg;
	word_t clkOutCtl_reg;
	word_t regMem [0:`REG_COUNT-1];

	logic portUp;
	logic sckRise;
	logic sckFall;
	logic csFall;
	logic csRise;
	logic active;
	logic sampleEn;
	logic shiftEn;
	logic loadEn;
	byte_t loadByte;
	byte_t rxByte;
	logic byteDone;
	logic serOut;
	logic wordWrite;
	logic hdrDone;
	logic dataDone;

	function automatic logic isClkOutCtl(input addr_t a);
		isClkOutCtl = (a == `ADDR_CLKOUT_CTL);
	endfunction

	function automatic byte_t readByte(input addr_t a, input word_t ctl, input word_t mem,
		input logic hi);
		word_t w;
		w = isClkOutCtl(a) ? ctl : mem;
		readByte = hi ? w[15:8] : w[7:0];
	endfunction

	function automatic addr_t nextAddr(input addr_t a);
		nextAddr = a + `ADDR_STEP;
	endfunction

	// Inputs are synchronous to clk; edges found by one-cycle history
	assign portUp = modemIdle & serialPortOn;
	assign sckRise = link.sck & ~sckPrev_reg;
	assign sckFall = ~link.sck & sckPrev_reg;
	assign csFall = ~link.csN & csPrev_reg;
	assign csRise = link.csN & ~csPrev_reg;
	assign active = ((state_reg == DEV_HEADER) || (state_reg == DEV_DATA)) & ~link.csN;
	assign sampleEn = active & sckRise;
	assign shiftEn = active & sckFall;
	assign hdrDone = byteDone & (state_reg == DEV_HEADER);
	assign dataDone = byteDone & (state_reg == DEV_DATA);
	assign wordWrite = dataDone & ~readAcc_reg & lowPhase_reg;

	// Read data loaded at each burst end, high byte first
	always_comb begin
		loadEn = 1'b0;
		loadByte = `BYTE_ZERO;
		if (hdrDone && rxByte[`HDR_RW_BIT]) begin
			loadEn = 1'b1;
			loadByte = readByte(rxByte[`HDR_ADDR_HI:`HDR_ADDR_LO], clkOutCtl_reg,
				regMem[rxByte[`HDR_ADDR_HI:`HDR_ADDR_LO]], 1'b1);
		end else if (dataDone && readAcc_reg && !lowPhase_reg) begin
			loadEn = 1'b1;
			loadByte = readByte(addr_reg, clkOutCtl_reg, regMem[addr_reg], 1'b0);
		end else if (dataDone && readAcc_reg && lowPhase_reg) begin
			loadEn = 1'b1;
			loadByte = readByte(nextAddr(addr_reg), clkOutCtl_reg,
				regMem[nextAddr(addr_reg)], 1'b1);
		end
	end

	byte_shifter shifter (
		.clk(clk),
		.rst_n(rst_n),
		.clear(csFall),
		.loadEn(loadEn),
		.loadByte(loadByte),
		.sampleEn(sampleEn),
		.shiftEn(shiftEn),
		.serIn(link.mosi),
		.serOut(serOut),
		.rxByte(rxByte),
		.byteDone(byteDone)
	);

	// The clock is only ever observed, never driven
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sckPrev_reg <= 1'b0;
			csPrev_reg <= 1'b1;
		end else begin
			sckPrev_reg <= link.sck;
			csPrev_reg <= link.csN;
		end
	end

	// Frame sequencing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= DEV_IDLE;
		end else begin
			case (state_reg)
				DEV_IDLE: begin
					if (csFall) begin
						state_reg <= portUp ? DEV_HEADER : DEV_IGNORE;
					end
				end
				DEV_HEADER: begin
					if (csRise) begin
						state_reg <= DEV_IDLE;
					end else if (!portUp) begin
						state_reg <= DEV_IGNORE;
					end else if (byteDone) begin
						state_reg <= DEV_DATA;
					end
				end
				DEV_DATA: begin
					if (csRise) begin
						state_reg <= DEV_IDLE;
					end else if (!portUp) begin
						state_reg <= DEV_IGNORE;
					end
				end
				default: begin
					if (link.csN) begin
						state_reg <= DEV_IDLE;
					end
				end
			endcase
		end
	end

	// Header capture and word position
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_reg <= 6'h00;
			readAcc_reg <= 1'b0;
			lowPhase_reg <= 1'b0;
			hiByte_reg <= `BYTE_ZERO;
		end else if (hdrDone) begin
			addr_reg <= rxByte[`HDR_ADDR_HI:`HDR_ADDR_LO];
			readAcc_reg <= rxByte[`HDR_RW_BIT];
			lowPhase_reg <= 1'b0;
		end else if (dataDone) begin
			lowPhase_reg <= ~lowPhase_reg;
			if (!lowPhase_reg) begin
				hiByte_reg <= rxByte;
			end else begin
				addr_reg <= nextAddr(addr_reg);
			end
		end
	end

	// Data line enabled only for read payload
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			misoOe_reg <= 1'b0;
		end else if (csRise || !active) begin
			misoOe_reg <= 1'b0;
		end else if (hdrDone) begin
			misoOe_reg <= rxByte[`HDR_RW_BIT];
		end
	end

	// Burst count checked at frame end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			byteCount_reg <= 2'h0;
			frameShort_reg <= 1'b0;
		end else if (csFall) begin
			byteCount_reg <= 2'h0;
		end else if (csRise && state_reg != DEV_IDLE && state_reg != DEV_IGNORE) begin
			frameShort_reg <= (byteCount_reg < `MIN_FRAME_BYTES);
		end else if (byteDone && byteCount_reg != `MIN_FRAME_BYTES) begin
			byteCount_reg <= byteCount_reg + 2'h1;
		end
	end

	// Word writes move into registers on the core clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clkOutCtl_reg <= `REG_RESET;
		end else if (wordWrite && isClkOutCtl(addr_reg)) begin
			clkOutCtl_reg <= {hiByte_reg, rxByte};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `REG_COUNT; i++) begin
				regMem[i] <= `REG_RESET;
			end
		end else if (wordWrite && !isClkOutCtl(addr_reg)) begin
			regMem[addr_reg] <= {hiByte_reg, rxByte};
		end
	end

	// Clock output: direct reference or power-of-two division
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			refPrev_reg <= 1'b0;
			refDiv_reg <= '0;
			refOut_reg <= 1'b0;
		end else begin
			refPrev_reg <= oscillatorInputPin;
			if (oscillatorInputPin && !refPrev_reg) begin
				refDiv_reg <= refDiv_reg + `REF_DIV_W'(1);
			end
			if (clkOutCtl_reg[`CLKSEL_HI:`CLKSEL_LO] == `CLKSEL_DIRECT) begin
				refOut_reg <= oscillatorInputPin;
			end else begin
				refOut_reg <= refDiv_reg[clkOutCtl_reg[`CLKSEL_HI:`CLKSEL_LO] - 3'h1];
			end
		end
	end

	assign link.miso = serOut;
	assign link.misoOe = misoOe_reg;
	// Zero trim is highest frequency; each step lowers it
	assign oscWarpTrim = clkOutCtl_reg[`TRIM_HI:`TRIM_LO];
	assign referenceClockOutPin = refOut_reg;
	assign frameShort = frameShort_reg;
endmodule
`default_nettype wire

// ==== design/host_serial_master.sv ====
// Host end of the serial link: register-driven serial master
`timescale 1ns/1ps
`default_nettype none
module host_serial_master (
	input wire logic clk,
	input wire logic rst_n,
	input wire modem_serial_pkg::host_addr_t regAddr,
	input wire modem_serial_pkg::word_t regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output modem_serial_pkg::word_t regRdata,
	serial_link_if.host link
);
	import modem_serial_pkg::*;

	host_state_t state_reg;
	logic [2:0] halfCnt_reg;
	logic [1:0] byteIdx_reg;
	logic lastDone_reg;
	logic sck_reg;
	logic csN_reg;
	addr_t addrSel_reg;
	logic readSel_reg;
	word_t txWord_reg;
	word_t rxWord_reg;
	byte_t rxHi_reg;
	logic doneFlag_reg;
	word_t rdata_reg;

	logic tick;
	logic go;
	logic sampleEn;
	logic shiftEn;
	logic loadEn;
	byte_t loadByte;
	byte_t rxByte;
	logic byteDone;
	logic finish;

	function automatic byte_t payloadByte(input logic rd, input byte_t b);
		payloadByte = rd ? `BYTE_ZERO : b;
	endfunction

	assign tick = (halfCnt_reg == `HALF_CNT_LAST);
	assign go = regWrite && regAddr == `HREG_CTRL && regWdata[`CTRL_GO_BIT] && state_reg == H_IDLE;
	assign sampleEn = (state_reg == H_LOW) & tick;
	assign shiftEn = (state_reg == H_HIGH) & tick;
	assign finish = (state_reg == H_TAIL) & tick;

	always_comb begin
		loadEn = 1'b0;
		loadByte = `BYTE_ZERO;
		if (go) begin
			loadEn = 1'b1;
			loadByte = {regWdata[`CTRL_READ_BIT], `HDR_UNUSED,
				regWdata[`HDR_ADDR_HI:`HDR_ADDR_LO]};
		end else if (byteDone && byteIdx_reg == `HOST_BYTE_HDR) begin
			loadEn = 1'b1;
			loadByte = payloadByte(readSel_reg, txWord_reg[15:8]);
		end else if (byteDone && byteIdx_reg == `HOST_BYTE_HI) begin
			loadEn = 1'b1;
			loadByte = payloadByte(readSel_reg, txWord_reg[7:0]);
		end
	end

	byte_shifter shifter (
		.clk(clk),
		.rst_n(rst_n),
		.clear(go),
		.loadEn(loadEn),
		.loadByte(loadByte),
		.sampleEn(sampleEn),
		.shiftEn(shiftEn),
		.serIn(link.misoLine),
		.serOut(link.mosi),
		.rxByte(rxByte),
		.byteDone(byteDone)
	);

	// Clock generation and framing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= H_IDLE;
			halfCnt_reg <= 3'h0;
			sck_reg <= 1'b0;
			csN_reg <= 1'b1;
		end else begin
			halfCnt_reg <= (state_reg == H_IDLE || tick) ? 3'h0 : halfCnt_reg + 3'h1;
			case (state_reg)
				H_IDLE: begin
					if (go) begin
						csN_reg <= 1'b0;
						state_reg <= H_LOW;
					end
				end
				H_LOW: begin
					if (tick) begin
						sck_reg <= 1'b1;
						state_reg <= H_HIGH;
					end
				end
				H_HIGH: begin
					if (tick) begin
						sck_reg <= 1'b0;
						state_reg <= lastDone_reg ? H_TAIL : H_LOW;
					end
				end
				default: begin
					if (tick) begin
						csN_reg <= 1'b1;
						state_reg <= H_IDLE;
					end
				end
			endcase
		end
	end

	// Three bursts: header then one word
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			byteIdx_reg <= `HOST_BYTE_HDR;
			lastDone_reg <= 1'b0;
			rxHi_reg <= `BYTE_ZERO;
			rxWord_reg <= `RDATA_IDLE;
		end else if (go) begin
			byteIdx_reg <= `HOST_BYTE_HDR;
			lastDone_reg <= 1'b0;
		end else if (byteDone) begin
			byteIdx_reg <= byteIdx_reg + 2'h1;
			if (byteIdx_reg == `HOST_BYTE_HI) begin
				rxHi_reg <= rxByte;
			end
			if (byteIdx_reg == `HOST_BYTE_LO) begin
				lastDone_reg <= 1'b1;
				if (readSel_reg) begin
					rxWord_reg <= {rxHi_reg, rxByte};
				end
			end
		end
	end

	// Command registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addrSel_reg <= 6'h00;
			readSel_reg <= 1'b0;
			txWord_reg <= `RDATA_IDLE;
		end else if (regWrite && regAddr == `HREG_CTRL && state_reg == H_IDLE) begin
			addrSel_reg <= regWdata[`HDR_ADDR_HI:`HDR_ADDR_LO];
			readSel_reg <= regWdata[`CTRL_READ_BIT];
		end else if (regWrite && regAddr == `HREG_TX && state_reg == H_IDLE) begin
			txWord_reg <= regWdata;
		end
	end

	// Done flag: set wins over read-clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			doneFlag_reg <= 1'b0;
		end else if (finish) begin
			doneFlag_reg <= 1'b1;
		end else if (regRead && regAddr == `HREG_STATUS) begin
			doneFlag_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= `RDATA_IDLE;
		end else if (!regRead) begin
			rdata_reg <= `RDATA_IDLE;
		end else if (regAddr == `HREG_CTRL) begin
			rdata_reg <= {8'h00, readSel_reg, 1'b0, addrSel_reg};
		end else if (regAddr == `HREG_TX) begin
			rdata_reg <= txWord_reg;
		end else if (regAddr == `HREG_RX) begin
			rdata_reg <= rxWord_reg;
		end else if (regAddr == `HREG_STATUS) begin
			rdata_reg <= {14'h0000, doneFlag_reg, state_reg != H_IDLE};
		end else begin
			rdata_reg <= `RDATA_IDLE;
		end
	end

	assign regRdata = rdata_reg;
	assign link.sck = sck_reg;
	assign link.csN = csN_reg;
endmodule
`default_nettype wire

// ==== verif/serial_link_chk.sv ====
// Concurrent checks on the host-to-modem serial link wires
`timescale 1ns/1ps
`default_nettype none
module serial_link_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sck,
	input wire logic csN,
	input wire logic mosi,
	input wire logic miso,
	input wire logic misoOe,
	input wire logic misoLine
);
	logic sckPrev_reg;
	logic [7:0] riseCnt_reg;
	logic hdrRead_reg;
	logic sckRise;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	assign sckRise = sck && !sckPrev_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) sckPrev_reg <= 1'b0;
		else sckPrev_reg <= sck;
	end

	// Serial clock rises seen in the current frame
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) riseCnt_reg <= 8'h00;
		else if (csN) riseCnt_reg <= 8'h00;
		else if (sckRise) riseCnt_reg <= riseCnt_reg + 8'h01;
	end

	// Direction flag taken from the first header bit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) hdrRead_reg <= 1'b0;
		else if (csN) hdrRead_reg <= 1'b0;
		else if (sckRise && riseCnt_reg == 8'h00) hdrRead_reg <= mosi;
	end

	sequence sckHigh2;
		sck [*2];
	endsequence

	sequence sckLow2;
		!sck [*2];
	endsequence

	a_sck_idle_low: assert property (csN |-> !sck)
		else $error("serial clock active outside frame");
	a_high_phase: assert property ($rose(sck) |-> sckHigh2)
		else $error("serial clock high phase too short");
	a_low_phase: assert property ($fell(sck) |-> sckLow2)
		else $error("serial clock low phase too short");
	a_frame_start: assert property ($fell(csN) |-> sckLow2)
		else $error("clock rose too soon after select");
	a_mosi_steady: assert property (sck |-> $stable(mosi))
		else $error("host data changed while clock high");
	a_miso_steady: assert property (sck && misoOe |-> $stable(miso))
		else $error("modem data changed while clock high");
	a_line_steady: assert property (sck |-> $stable(misoLine))
		else $error("data line changed while clock high");
	a_oe_outside: assert property (csN && $past(csN) |-> !misoOe)
		else $error("modem drives data outside frame");
	a_header_quiet: assert property (!csN && riseCnt_reg < 8'h08 |-> !misoOe)
		else $error("modem drives data during header");
	a_write_quiet: assert property (!csN && !hdrRead_reg |-> !misoOe)
		else $error("modem drives data in write frame");
	a_read_drive: assert property (sckRise && hdrRead_reg && riseCnt_reg >= 8'h08
		&& riseCnt_reg < 8'h18 |-> misoOe)
		else $error("modem silent in read payload");
	a_frame_length: assert property ($rose(csN) |-> riseCnt_reg == 8'h18)
		else $error("frame bit count wrong");
endmodule
`default_nettype wire

// ==== verif/radio_modem_serial_slave_port_tb.sv ====
// Self-checking bench joining host master and modem slave
`timescale 1ns/1ps
`default_nettype none
`include "modem_serial_params.svh"
module radio_modem_serial_slave_port_tb;
	import modem_serial_pkg::*;
	logic clk;
	logic rst_n;
	host_addr_t regAddr;
	word_t regWdata;
	logic regWrite;
	logic regRead;
	word_t regRdata;
	logic modemIdle;
	logic serialPortOn;
	logic oscillatorInputPin;
	logic [7:0] oscWarpTrim;
	logic referenceClockOutPin;
	logic frameShort;
	int errors;
	int checked;
	word_t expMem [64];
	word_t got;
	word_t w;
	addr_t a;
	int seed;

	serial_link_if link();
	modem_serial_slave i_modem_serial_slave (.clk(clk), .rst_n(rst_n), .link(link.device),
		.modemIdle(modemIdle), .serialPortOn(serialPortOn),
		.oscillatorInputPin(oscillatorInputPin), .oscWarpTrim(oscWarpTrim),
		.referenceClockOutPin(referenceClockOutPin), .frameShort(frameShort));
	host_serial_master i_host_serial_master (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.link(link.host));
	serial_link_chk i_serial_link_chk (.clk(clk), .rst_n(rst_n), .sck(link.sck),
		.csN(link.csN), .mosi(link.mosi), .miso(link.miso), .misoOe(link.misoOe),
		.misoLine(link.misoLine));

	initial clk = 1'b0;
	always #20 clk = ~clk;
	// Reference toggles every core cycle
	always @(posedge clk) oscillatorInputPin <= ~oscillatorInputPin;

	function automatic word_t ctrlWord(input logic rd, input addr_t ad);
		word_t c;
		c = 16'h0000;
		c[`CTRL_GO_BIT] = 1'b1;
		c[`CTRL_READ_BIT] = rd;
		c[5:0] = ad;
		return c;
	endfunction

	function automatic word_t trimOf(input word_t v);
		return {8'h00, v[15:8]};
	endfunction

	task automatic end_of_test;
		$display("compares %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input word_t seen, input word_t exp, input string what);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
		end
	endtask

	task automatic regWr(input host_addr_t ra, input word_t d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= ra;
		regWdata <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask

	task automatic regRd(input host_addr_t ra, output word_t d);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= ra;
		@(posedge clk);
		regRead <= 1'b0;
		#1 d = regRdata;
	endtask

	task automatic waitDone;
		word_t s;
		int n;
		for (n = 0; n < 300; n++) begin
			regRd(`HREG_STATUS, s);
			if (s[`STAT_DONE_BIT] === 1'b1) break;
		end
		if (n == 300) begin
			errors++;
			$display("BAD %0t transfer never finished", $time);
			end_of_test();
		end
	endtask

	task automatic linkWrite(input addr_t ad, input word_t d);
		regWr(`HREG_TX, d);
		regWr(`HREG_CTRL, ctrlWord(1'b0, ad));
		waitDone();
	endtask

	task automatic linkRead(input addr_t ad, output word_t d);
		regWr(`HREG_CTRL, ctrlWord(1'b1, ad));
		waitDone();
		regRd(`HREG_RX, d);
	endtask

	initial begin
		rst_n = 1'b0;
		regAddr = 4'h0;
		regWdata = 16'h0000;
		regWrite = 1'b0;
		regRead = 1'b0;
		modemIdle = 1'b1;
		serialPortOn = 1'b1;
		oscillatorInputPin = 1'b0;
		errors = 0;
		checked = 0;
		foreach (expMem[i]) expMem[i] = 16'h0000;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		seed = $urandom(51530);

		check({8'h00, oscWarpTrim}, 16'h0000, "trim after reset");
		linkRead(6'h0A, got);
		check(got, 16'h0000, "clock-out reset");
		regRd(4'h7, got);
		check(got, `RDATA_IDLE, "unmapped read");
		$display("test reset done");

		for (int k = 0; k < 4; k++) begin
			w = word_t'($urandom) & 16'hFFF8;
			if (k == 0) w[15:8] = 8'h00;
			if (k == 1) w[15:8] = 8'hFF;
			linkWrite(6'h0A, w);
			expMem[6'h0A] = w;
			check({8'h00, oscWarpTrim}, trimOf(w), "trim field");
			repeat (4) begin
				@(posedge clk);
				#1 got = {15'h0000, ~oscillatorInputPin};
				check({15'h0000, referenceClockOutPin}, got, "clock out");
			end
		end
		$display("test trim done");

		for (int i = 0; i < 12; i++) begin
			a = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : addr_t'($urandom);
			w = word_t'($urandom);
			linkWrite(a, w);
			expMem[a] = w;
			linkRead(a, got);
			check(got, expMem[a], "random word");
		end
		linkRead(6'h0A, got);
		check(got, expMem[6'h0A], "clock-out kept");
		$display("test random done");

		a = addr_t'($urandom);
		w = word_t'($urandom);
		regWr(`HREG_TX, w);
		regWr(`HREG_CTRL, ctrlWord(1'b0, a));
		regRd(`HREG_STATUS, got);
		check({15'h0000, got[`STAT_BUSY_BIT]}, 16'h0001, "busy flag");
		regWr(`HREG_TX, ~w);
		regWr(`HREG_CTRL, ctrlWord(1'b0, a ^ 6'h01));
		waitDone();
		expMem[a] = w;
		linkRead(a, got);
		check(got, w, "write while busy");
		linkRead(a ^ 6'h01, got);
		check(got, expMem[a ^ 6'h01], "go while busy");
		$display("test busy done");

		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			modemIdle <= k[0];
			serialPortOn <= ~k[0];
			a = addr_t'($urandom);
			linkWrite(a, ~expMem[a]);
			@(posedge clk);
			modemIdle <= 1'b1;
			serialPortOn <= 1'b1;
			linkRead(a, got);
			check(got, expMem[a], "disabled port");
		end
		$display("test disabled done");

		check({15'h0000, frameShort}, 16'h0000, "short frame flag");
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		check({8'h00, oscWarpTrim}, 16'h0000, "trim after second reset");
		linkRead(`ADDR_CLKOUT_CTL, got);
		check(got, `REG_RESET, "clock-out after second reset");
		$display("test second reset done");
		end_of_test();
	end
endmodule
`default_nettype wire
